/* hw/lsag_unit.sv */
// load/store address generation and load write-back unit
`timescale 1ns/100ps
`default_nettype none
module lsag_unit import lsag_pkg::*; (
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire logic              reqValid,
   input  wire lsag_req_t         req,
   output var  logic              reqBusy,
   output var  logic              memReq,
   output var  logic              memWe,
   output var  logic [1:0]        memSize,
   output var  logic [ADDR_W-1:0] memAddr,
   output var  logic [ADDR_W-1:0] memWdata,
   input  wire logic              memAck,
   input  wire logic [ADDR_W-1:0] memRdata,
   output var  lsag_wr_t          destWr,
   output var  lsag_wr_t          baseWr
);

   // ==========================================================
   // all checks sample on clk and sleep while reset is low
   default clocking assertClk @(posedge clk);
   endclocking
   default disable iff (!resetn);

   // ==========================================================
   // address and fill functions
   function automatic logic [ADDR_W-1:0] calcAddr(input lsag_req_t r);
      logic [ADDR_W-1:0] baseVal;
      logic [ADDR_W-1:0] dispExt;
      baseVal = (r.baseSel == SEL_ZERO) ? ADDR_RST : r.baseData;
      dispExt = {{(ADDR_W-DISP_W){r.disp[DISP_W-1]}}, r.disp};
      case (r.mode)
         MODE_DISP:  calcAddr = baseVal + dispExt;
         MODE_INDEX: calcAddr = baseVal + r.indexData;
         default:    calcAddr = baseVal;
      endcase
   endfunction

   function automatic logic [ADDR_W-1:0] zeroFill(input logic [1:0] sz,
                                                  input logic [ADDR_W-1:0] d);
      case (sz)
         SIZE_BYTE: zeroFill = {24'h000000, d[7:0]};
         SIZE_HALF: zeroFill = {16'h0000, d[15:0]};
         default:   zeroFill = d;
      endcase
   endfunction

   // ==========================================================
   // state
   lsag_state_t s_reg;
   lsag_state_t s_next;
   logic        reqTaken;

   assign reqTaken = reqValid && !s_reg.busy;

   always_comb begin
      s_next = s_reg;
      s_next.dest.we = 1'b0;
      s_next.base.we = 1'b0;
      case (s_reg.phase)
         LSAG_IDLE: begin
            if (reqValid) begin
               s_next.phase  = LSAG_ACCESS;
               s_next.busy   = 1'b1;
               s_next.load   = req.load;
               s_next.update = req.update;
               s_next.size   = req.size;
               s_next.memReq = 1'b1;
               s_next.memWe  = !req.load;
               s_next.addr   = calcAddr(req);
               s_next.wdata  = req.storeData;
               s_next.dest.sel = req.destSel;
               s_next.base.sel = req.baseSel;
            end
         end
         LSAG_ACCESS: begin
            if (memAck) begin
               s_next.memReq = 1'b0;
               s_next.memWe  = 1'b0;
               s_next.phase  = LSAG_WRITE;
               s_next.dest.we = s_reg.load;
               s_next.dest.data = zeroFill(s_reg.size, memRdata);
               // base-equals-dest: memory data wins, no address write
               s_next.base.we = s_reg.load && s_reg.update
                  && (s_reg.base.sel != s_reg.dest.sel);
               s_next.base.data = s_reg.addr;
            end
         end
         LSAG_WRITE: begin
            s_next.phase = LSAG_IDLE;
            s_next.busy  = 1'b0;
         end
         default: begin
            s_next.phase = LSAG_IDLE;
            s_next.busy  = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign reqBusy  = s_reg.busy;
   assign memReq   = s_reg.memReq;
   assign memWe    = s_reg.memWe;
   assign memSize  = s_reg.size;
   assign memAddr  = s_reg.addr;
   assign memWdata = s_reg.wdata;
   assign destWr   = s_reg.dest;
   assign baseWr   = s_reg.base;

   // ==========================================================
   // checks on the address path
   a_disp_base_sum: assert property (
      reqTaken && req.mode == MODE_DISP && req.baseSel != SEL_ZERO
      |=> memReq && memAddr == ADDR_W'($past(req.baseData)
          + {{16{$past(req.disp[15])}}, $past(req.disp)}))
      else $error("displacement address wrong");

   a_disp_zero_base: assert property (
      reqTaken && req.mode == MODE_DISP && req.baseSel == SEL_ZERO
      |=> memAddr == {{16{$past(req.disp[15])}}, $past(req.disp)})
      else $error("displacement with zero base wrong");

   a_index_sum: assert property (
      reqTaken && req.mode == MODE_INDEX && req.baseSel != SEL_ZERO
      |=> memAddr == ADDR_W'($past(req.baseData) + $past(req.indexData)))
      else $error("indexed address wrong");

   a_index_zero_base: assert property (
      reqTaken && req.mode == MODE_INDEX && req.baseSel == SEL_ZERO
      |=> memAddr == $past(req.indexData))
      else $error("indexed with zero base wrong");

   a_reg_only_addr: assert property (
      reqTaken && req.mode == MODE_REG
      |=> memAddr == (($past(req.baseSel) == SEL_ZERO) ? ADDR_RST
                      : $past(req.baseData)))
      else $error("register-only address wrong");

   a_wrap_no_trap: assert property (
      reqTaken && req.mode == MODE_INDEX && req.baseSel != SEL_ZERO
      && req.baseData > ~req.indexData
      |=> memReq && memAddr < $past(req.baseData))
      else $error("address sum did not wrap");

   // ==========================================================
   // checks on the write-back path
   a_load_writes_dest: assert property (
      memReq && memAck && !memWe
      |=> destWr.we && !memReq ##1 !destWr.we && !reqBusy)
      else $error("load did not write destination");

   a_update_base_addr: assert property (
      baseWr.we |-> baseWr.data == memAddr && destWr.we
      && baseWr.sel != destWr.sel)
      else $error("update base write wrong");

   a_update_zero_base: assert property (
      memReq && memAck && !memWe && s_reg.update
      && s_reg.base.sel == SEL_ZERO && s_reg.dest.sel != SEL_ZERO
      |=> baseWr.we && baseWr.sel == SEL_ZERO)
      else $error("update with zero base not written");

   a_same_base_dest: assert property (
      destWr.we && baseWr.sel == destWr.sel |-> !baseWr.we)
      else $error("base equal dest wrote address");

   a_byte_fill: assert property (
      memReq && memAck && memSize == SIZE_BYTE
      |=> destWr.data == {24'h000000, $past(memRdata[7:0])})
      else $error("byte fill wrong");

   a_half_fill: assert property (
      memReq && memAck && memSize == SIZE_HALF
      |=> destWr.data == {16'h0000, $past(memRdata[15:0])})
      else $error("half-word fill wrong");

   // ==========================================================
   // checks on the memory handshake and on register writes
   a_take_starts: assert property (
      reqTaken |=> memReq && reqBusy)
      else $error("request not started");

   a_req_holds: assert property (
      memReq && !memAck
      |=> memReq && $stable(memAddr) && $stable(memWe) && $stable(memSize))
      else $error("memory request dropped early");

   a_busy_drops: assert property (
      memReq && memAck |-> ##2 !reqBusy)
      else $error("busy did not drop after access");

   a_we_one_pulse: assert property (
      destWr.we |=> !destWr.we)
      else $error("destination write longer than one cycle");

   a_word_passes: assert property (
      memReq && memAck && !memWe && memSize == SIZE_WORD
      |=> destWr.we && destWr.data == $past(memRdata))
      else $error("word load data wrong");

   a_store_no_write: assert property (
      memReq && memAck && memWe |=> !destWr.we && !baseWr.we)
      else $error("store wrote a register");

   a_plain_no_base: assert property (
      memReq && memAck && !s_reg.update |=> !baseWr.we)
      else $error("load without update wrote base");

   // base update reuses the held address, so it must not move mid-access
   a_addr_stands: assert property (
      reqBusy |=> $stable(memAddr))
      else $error("address moved during access");

endmodule // lsag_unit
`default_nettype wire

/* hw/lsag_pkg.sv */
// load/store address generation: shared types and constants
// Summary of operation
// - Displacement mode adds the sign-extended 16-bit offset to the base.
// - Displacement with base selector zero adds zero, not register zero.
// - Indexed mode adds the base register and the index register.
// - Indexed mode with base selector zero yields the index register alone.
// - Register-only mode uses the base register, or zero for selector zero.
// - Loads put the byte, half-word or word at the address into the target.
// - Update loads, base nonzero and not the target: address goes to base.
// - Update with base zero: no trap, the address goes to register zero.
// - Update with base equal to target only loads that register from memory.
// - Byte loads fill the low eight bits and clear the rest.
// - Half-word loads fill the low sixteen bits and clear the rest.
package lsag_pkg;

   // ==========================================================
   // widths
   localparam int ADDR_W = 32;
   localparam int SEL_W  = 5;
   localparam int DISP_W = 16;

   // ==========================================================
   // encodings
   localparam logic [1:0] MODE_DISP  = 2'h0;
   localparam logic [1:0] MODE_INDEX = 2'h1;
   localparam logic [1:0] MODE_REG   = 2'h2;
   localparam logic [1:0] SIZE_BYTE  = 2'h0;
   localparam logic [1:0] SIZE_HALF  = 2'h1;
   localparam logic [1:0] SIZE_WORD  = 2'h2;
   localparam logic [SEL_W-1:0]  SEL_ZERO  = 5'h00;
   localparam logic [ADDR_W-1:0] ADDR_RST  = 32'h00000000;

   // ==========================================================
   // types
   typedef enum logic [1:0] {
      LSAG_IDLE   = 2'h0,
      LSAG_ACCESS = 2'h1,
      LSAG_WRITE  = 2'h3
   } lsag_phase_t;

   typedef struct packed {
      logic [1:0]        mode;
      logic [1:0]        size;
      logic              load;
      logic              update;
      logic [SEL_W-1:0]  baseSel;
      logic [SEL_W-1:0]  destSel;
      logic [DISP_W-1:0] disp;
      logic [ADDR_W-1:0] baseData;
      logic [ADDR_W-1:0] indexData;
      logic [ADDR_W-1:0] storeData;
   } lsag_req_t;

   typedef struct packed {
      logic              we;
      logic [SEL_W-1:0]  sel;
      logic [ADDR_W-1:0] data;
   } lsag_wr_t;

   typedef struct packed {
      lsag_phase_t       phase;
      logic              busy;
      logic              load;
      logic              update;
      logic [1:0]        size;
      logic              memReq;
      logic              memWe;
      logic [ADDR_W-1:0] addr;
      logic [ADDR_W-1:0] wdata;
      lsag_wr_t          dest;
      lsag_wr_t          base;
   } lsag_state_t;

endpackage

/* sim/lsag_mem_model.sv */
// memory access unit model facing the address generation unit
`timescale 1ns/100ps
`default_nettype none
module lsag_mem_model import lsag_pkg::*; (
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire logic [2:0]        waitCycles,
   input  wire logic              memReq,
   input  wire logic [1:0]        memSize,
   input  wire logic [ADDR_W-1:0] memAddr,
   output var  logic              memAck,
   output var  logic [ADDR_W-1:0] memRdata
);
   logic [2:0]        cnt;
   logic [ADDR_W-1:0] word;
   assign word = memAddr ^ 32'h5A3C96E1;
   always_ff @(posedge clk) begin
      memAck <= 1'b0;
      if (!resetn) begin
         cnt <= 3'h0;
         memRdata <= 32'hA5A5A5A5;
      end else if (memReq && !memAck && cnt == waitCycles) begin
         cnt <= 3'h0;
         memAck <= 1'b1;
         // narrow elements arrive with junk above them: the unit must clear it
         if (memSize == SIZE_BYTE || memSize == SIZE_HALF)
            memRdata <= word | 32'hFFFF0000;
         else
            memRdata <= word;
      end else begin
         if (memReq && !memAck) cnt <= cnt + 3'h1;
         // no stale data outside the ack cycle
         memRdata <= ~memRdata;
      end
   end
endmodule // lsag_mem_model
`default_nettype wire

/* sim/lsag_unit_tb_top.sv */
// self-checking bench for the load/store address generation unit
`timescale 1ns/100ps
`default_nettype none
`define CHECK(g, e) begin samplesChecked++; if ((g) !== (e)) begin \
   nFail++; $display("wrong value at %0t: got %h expected %h", \
   $time, g, e); end end
module lsag_unit_tb_top import lsag_pkg::*;;
   logic              clk, resetn, reqValid, reqBusy;
   logic              memReq, memWe, memAck;
   logic [1:0]        memSize;
   logic [2:0]        waitCycles;
   logic [ADDR_W-1:0] memAddr, memWdata, memRdata;
   lsag_req_t         req;
   lsag_wr_t          destWr, baseWr;
   int                nFail, samplesChecked;

   lsag_unit u_dut (.clk(clk), .resetn(resetn), .reqValid(reqValid),
      .req(req), .reqBusy(reqBusy), .memReq(memReq), .memWe(memWe),
      .memSize(memSize), .memAddr(memAddr), .memWdata(memWdata),
      .memAck(memAck), .memRdata(memRdata), .destWr(destWr),
      .baseWr(baseWr));
   lsag_mem_model u_mem (.clk(clk), .resetn(resetn),
      .waitCycles(waitCycles), .memReq(memReq), .memSize(memSize),
      .memAddr(memAddr), .memAck(memAck), .memRdata(memRdata));

   // ==========================================================
   // shared tasks
   function automatic logic [ADDR_W-1:0] elem(logic [ADDR_W-1:0] a,
                                              logic [1:0] s);
      logic [ADDR_W-1:0] w;
      w = a ^ 32'h5A3C96E1;
      if (s == SIZE_BYTE) return {24'h000000, w[7:0]};
      if (s == SIZE_HALF) return {16'h0000, w[15:0]};
      return w;
   endfunction

   task automatic op(input logic [1:0] md, sz, input logic ld, up,
      input logic [SEL_W-1:0] bs, ds, input logic [DISP_W-1:0] d,
      input logic [ADDR_W-1:0] bd, xd);
      logic [ADDR_W-1:0] ea, b;
      lsag_wr_t          gotD, gotB, expD, expB;
      b = (bs == SEL_ZERO) ? 32'h0 : bd;
      ea = (md == MODE_DISP) ? b + {{16{d[15]}}, d} :
           (md == MODE_INDEX) ? b + xd : b;
      expD = ld ? {1'b1, ds, elem(ea, sz)} : '0;
      expB = (ld && up && bs != ds) ? {1'b1, bs, ea} : '0;
      gotD = '0;
      gotB = '0;
      req = '{md, sz, ld, up, bs, ds, d, bd, xd, ~bd};
      reqValid = 1'b1;
      @(posedge clk);
      #1 reqValid = 1'b0;
      `CHECK({reqBusy, memReq}, 2'h3)
      for (int i = 0; i < 20; i++) begin
         if (memReq) begin
            `CHECK({memWe, memSize, memAddr}, {!ld, sz, ea})
            if (!ld) `CHECK(memWdata, ~bd)
         end
         @(posedge clk);
         #1;
         if (destWr.we) gotD = destWr;
         if (baseWr.we) gotB = baseWr;
         if (!reqBusy) break;
      end
      `CHECK(reqBusy, 1'b0)
      `CHECK(gotD, expD)
      `CHECK(gotB, expB)
   endtask

   // ==========================================================
   // scenarios
   task automatic test_addr;
      waitCycles = 3'h0;
      op(MODE_DISP, SIZE_WORD, 1'b1, 1'b0, 5'h03, 5'h04, 16'hFFF0,
         32'h00001000, 32'h0);
      op(MODE_DISP, SIZE_WORD, 1'b1, 1'b0, SEL_ZERO, 5'h04, 16'h7FFC,
         32'h12345678, 32'h0);
      op(MODE_DISP, SIZE_WORD, 1'b0, 1'b1, 5'h07, 5'h04, 16'h0010,
         32'hFFFFFFF8, 32'h0);
      op(MODE_INDEX, SIZE_HALF, 1'b1, 1'b0, 5'h02, 5'h01, 16'h0,
         32'h80000000, 32'h80000004);
      op(MODE_INDEX, SIZE_BYTE, 1'b1, 1'b0, SEL_ZERO, 5'h01, 16'h0,
         32'hDEADBEEF, 32'h00000100);
      op(MODE_REG, SIZE_BYTE, 1'b1, 1'b0, 5'h09, 5'h0A, 16'hFFFF,
         32'h00ABCDEF, 32'h00000010);
      op(MODE_REG, SIZE_WORD, 1'b1, 1'b0, SEL_ZERO, 5'h0A, 16'hFFFF,
         32'hFFFFFFFF, 32'h00000010);
      // mode and size code 3 fall back to register-only and word
      op(2'h3, 2'h3, 1'b1, 1'b0, 5'h0B, 5'h0C, 16'h1234,
         32'hC0FFEE00, 32'h00000040);
      $display("test_addr done");
   endtask

   task automatic test_update;
      // slow memory stretches the access
      waitCycles = 3'h3;
      op(MODE_DISP, SIZE_WORD, 1'b1, 1'b1, 5'h05, 5'h06, 16'h8000,
         32'h00010000, 32'h0);
      op(MODE_DISP, SIZE_BYTE, 1'b1, 1'b1, SEL_ZERO, 5'h06, 16'h0040,
         32'h55555555, 32'h0);
      op(MODE_DISP, SIZE_HALF, 1'b1, 1'b1, 5'h06, 5'h06, 16'h0002,
         32'h00002000, 32'h0);
      op(MODE_INDEX, SIZE_HALF, 1'b1, 1'b1, 5'h01, 5'h02, 16'h0,
         32'h00003000, 32'h00000022);
      $display("test_update done");
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", samplesChecked, nFail);
      if (nFail == 0 && samplesChecked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   initial begin
      repeat (2000) @(posedge clk);
      nFail++;
      finish_test;
   end

   initial begin
      resetn = 1'b0;
      reqValid = 1'b0;
      req = '0;
      waitCycles = 3'h0;
      repeat (5) @(posedge clk);
      #1 resetn = 1'b1;
      @(posedge clk);
      #1;
      `CHECK({reqBusy, memReq, destWr.we, baseWr.we}, 4'h0)
      test_addr;
      test_update;
      finish_test;
   end
endmodule // lsag_unit_tb_top
`default_nettype wire
